// ==== core/lane_sat_unit.sv ====
// Purpose: Lane-wise unsigned saturating add and subtract.
// Assumes: Purely combinational; the caller registers the result.
// Notes: Lane width is a parameter, so one instance serves bytes or halves.
`timescale 1ns/1ps
module lane_sat_unit #(
	parameter int LANE_W = 8,
	parameter int DATA_W = 32
) (
	input wire logic [DATA_W-1:0] a,
	input wire logic [DATA_W-1:0] b,
	input wire logic do_sub,
	output wire logic [DATA_W-1:0] y
);
	localparam int LANES = DATA_W / LANE_W;

	for (genvar i = 0; i < LANES; i++)
	begin : g_lane
		logic [LANE_W:0] ext_sum;
		logic [LANE_W:0] ext_dif;
		logic [LANE_W-1:0] lane_y;
		assign ext_sum = {1'b0, a[i*LANE_W +: LANE_W]}
			+ {1'b0, b[i*LANE_W +: LANE_W]};
		assign ext_dif = {1'b0, a[i*LANE_W +: LANE_W]}
			- {1'b0, b[i*LANE_W +: LANE_W]};
		// A carry out clamps high; a borrow out clamps to zero.
		// Each lane owns its own variable, so no two processes share y.
		always_comb
		begin
			if (!do_sub)
				lane_y = ext_sum[LANE_W] ? {LANE_W{1'b1}}
					: ext_sum[LANE_W-1:0];
			else
				lane_y = ext_dif[LANE_W] ? {LANE_W{1'b0}}
					: ext_dif[LANE_W-1:0];
		end
		assign y[i*LANE_W +: LANE_W] = lane_y;
	end
endmodule : lane_sat_unit

// ==== core/sat_pack_alu_map.svh ====
// Purpose: Field positions, widths and encodings for the pack/extend unit.
// Assumes: Included by the package and the datapath files.
// Notes: Definitions only.
`ifndef SAT_PACK_ALU_MAP_SVH
`define SAT_PACK_ALU_MAP_SVH
`define SPA_DATA_W 32
`define SPA_HALF_W 16
`define SPA_BYTE_W 8
`define SPA_SHAMT_W 5
`define SPA_ROT_W 2
`define SPA_OP_W 5
`define SPA_ASR_FULL 6'h20
`define SPA_RESULT_RST 32'h0000_0000
`define SPA_FLAGS_RST 4'h0
`endif

// ==== core/sat_pack_alu_pkg.sv ====
// Purpose: Operation codes for the saturating pack and extend unit.
// Assumes: The map header is on the include path.
// Notes: Codes are packed and dense; unknown codes leave the result alone.
`include "sat_pack_alu_map.svh"
package sat_pack_alu_pkg;
	typedef enum logic [`SPA_OP_W-1:0] {
		OP_USAT_ADD_HALVES = 5'h00,
		OP_USAT_ADD_BYTES = 5'h01,
		OP_USAT_SUB_HALVES = 5'h02,
		OP_USAT_SUB_BYTES = 5'h03,
		OP_PACK_BOTTOM_TOP = 5'h04,
		OP_PACK_TOP_BOTTOM = 5'h05,
		OP_SIGN_WIDEN_BYTE = 5'h06,
		OP_SIGN_WIDEN_HALF = 5'h07,
		OP_SIGN_WIDEN_DUAL_BYTE = 5'h08,
		OP_ZERO_WIDEN_BYTE = 5'h09,
		OP_ZERO_WIDEN_HALF = 5'h0a,
		OP_ZERO_WIDEN_DUAL_BYTE = 5'h0b,
		OP_SIGN_WIDEN_BYTE_ADD = 5'h0c,
		OP_SIGN_WIDEN_HALF_ADD = 5'h0d,
		OP_SIGN_WIDEN_DUAL_BYTE_ADD = 5'h0e,
		OP_ZERO_WIDEN_BYTE_ADD = 5'h0f,
		OP_ZERO_WIDEN_HALF_ADD = 5'h10,
		OP_ZERO_WIDEN_DUAL_BYTE_ADD = 5'h11
	} alu_op_e;
endpackage : sat_pack_alu_pkg

// ==== core/saturating_pack_extend_alu.sv ====
// Purpose: Execute-stage unit for unsigned saturating lane arithmetic,
//          halfword packing and sign or zero widening with optional add.
// Assumes: Operands and controls are valid on the cycle START is high.
// Notes: One cycle of latency; RESULT and DONE are registered.
`timescale 1ns/1ps
`include "sat_pack_alu_map.svh"
module saturating_pack_extend_alu #(
	parameter int DATA_W = `SPA_DATA_W
) (
	input wire logic MCLK,
	input wire logic ARST_N,
	input wire logic START,
	input wire logic [`SPA_OP_W-1:0] OPCODE,
	input wire logic [DATA_W-1:0] FIRST_OPERAND,
	input wire logic [DATA_W-1:0] SECOND_OPERAND,
	input wire logic [`SPA_SHAMT_W-1:0] SHIFT_AMOUNT,
	input wire logic [`SPA_ROT_W-1:0] ROTATE_RIGHT_SELECT,
	input wire logic [3:0] FLAGS_IN,
	output logic [DATA_W-1:0] RESULT,
	output logic [3:0] FLAGS_OUT,
	output logic DONE,
	output logic BAD_OPCODE
);
	localparam int HW = `SPA_HALF_W;
	localparam int BW = `SPA_BYTE_W;

	logic [DATA_W-1:0] result_q;
	logic [DATA_W-1:0] result_d;
	logic [3:0] flags_q;
	logic done_q;
	logic bad_q;
	logic bad_d;
	logic [DATA_W-1:0] sat_half;
	logic [DATA_W-1:0] sat_byte;
	logic sub_sel;
	logic [DATA_W-1:0] lsl_val;
	logic [DATA_W-1:0] asr_val;
	logic [DATA_W-1:0] rotated;
	sat_pack_alu_pkg::alu_op_e op;

	assign op = sat_pack_alu_pkg::alu_op_e'(OPCODE);

	// Rotate right by whole bytes; used by every widen form.
	function automatic logic [DATA_W-1:0] rotate_bytes(
		input logic [DATA_W-1:0] v,
		input logic [`SPA_ROT_W-1:0] sel
	);
		logic [2*DATA_W-1:0] dbl;
		dbl = {v, v};
		return dbl[sel*BW +: DATA_W];
	endfunction : rotate_bytes

	// Widen a byte to a halfword, signed or unsigned.
	function automatic logic [HW-1:0] widen_byte_half(
		input logic [BW-1:0] v,
		input logic signed_fill
	);
		return {{(HW-BW){signed_fill & v[BW-1]}}, v};
	endfunction : widen_byte_half

	// Two widened bytes, low from bits 7..0, high from bits 23..16.
	function automatic logic [DATA_W-1:0] widen_dual(
		input logic [DATA_W-1:0] v,
		input logic signed_fill
	);
		return {widen_byte_half(v[2*HW-BW-1 -: BW], signed_fill),
			widen_byte_half(v[BW-1:0], signed_fill)};
	endfunction : widen_dual

	// Per-halfword wrapping add for the dual widen-add forms.
	function automatic logic [DATA_W-1:0] add_halves(
		input logic [DATA_W-1:0] a,
		input logic [DATA_W-1:0] b
	);
		logic [HW-1:0] lo;
		logic [HW-1:0] hi;
		lo = a[HW-1:0] + b[HW-1:0];
		hi = a[DATA_W-1:HW] + b[DATA_W-1:HW];
		return {hi, lo};
	endfunction : add_halves

	assign sub_sel = (op == sat_pack_alu_pkg::OP_USAT_SUB_HALVES)
		|| (op == sat_pack_alu_pkg::OP_USAT_SUB_BYTES);

	lane_sat_unit #(
		.LANE_W(HW),
		.DATA_W(DATA_W)
	) u_sat_half (
		.a(FIRST_OPERAND),
		.b(SECOND_OPERAND),
		.do_sub(sub_sel),
		.y(sat_half)
	);

	lane_sat_unit #(
		.LANE_W(BW),
		.DATA_W(DATA_W)
	) u_sat_byte (
		.a(FIRST_OPERAND),
		.b(SECOND_OPERAND),
		.do_sub(sub_sel),
		.y(sat_byte)
	);

	// A zero field already yields an unshifted operand.
	assign lsl_val = SECOND_OPERAND << SHIFT_AMOUNT;

	// A zero field selects a full 32-bit shift, leaving only sign copies.
	always_comb
	begin
		if (SHIFT_AMOUNT == '0)
			asr_val = {DATA_W{SECOND_OPERAND[DATA_W-1]}};
		else
			asr_val = DATA_W'($signed(SECOND_OPERAND) >>> SHIFT_AMOUNT);
	end

	assign rotated = rotate_bytes(SECOND_OPERAND, ROTATE_RIGHT_SELECT);

	always_comb
	begin
		result_d = result_q;
		bad_d = 1'b0;
		unique case (op)
			sat_pack_alu_pkg::OP_USAT_ADD_HALVES,
			sat_pack_alu_pkg::OP_USAT_SUB_HALVES:
				result_d = sat_half;
			sat_pack_alu_pkg::OP_USAT_ADD_BYTES,
			sat_pack_alu_pkg::OP_USAT_SUB_BYTES:
				result_d = sat_byte;
			sat_pack_alu_pkg::OP_PACK_BOTTOM_TOP:
				result_d = {lsl_val[DATA_W-1:HW],
					FIRST_OPERAND[HW-1:0]};
			sat_pack_alu_pkg::OP_PACK_TOP_BOTTOM:
				result_d = {FIRST_OPERAND[DATA_W-1:HW],
					asr_val[HW-1:0]};
			sat_pack_alu_pkg::OP_SIGN_WIDEN_BYTE:
				result_d = {{(DATA_W-BW){rotated[BW-1]}},
					rotated[BW-1:0]};
			sat_pack_alu_pkg::OP_ZERO_WIDEN_BYTE:
				result_d = {{(DATA_W-BW){1'b0}}, rotated[BW-1:0]};
			sat_pack_alu_pkg::OP_SIGN_WIDEN_HALF:
				result_d = {{(DATA_W-HW){rotated[HW-1]}},
					rotated[HW-1:0]};
			sat_pack_alu_pkg::OP_ZERO_WIDEN_HALF:
				result_d = {{(DATA_W-HW){1'b0}}, rotated[HW-1:0]};
			sat_pack_alu_pkg::OP_SIGN_WIDEN_DUAL_BYTE:
				result_d = widen_dual(rotated, 1'b1);
			sat_pack_alu_pkg::OP_ZERO_WIDEN_DUAL_BYTE:
				result_d = widen_dual(rotated, 1'b0);
			sat_pack_alu_pkg::OP_SIGN_WIDEN_BYTE_ADD:
				result_d = FIRST_OPERAND + {{(DATA_W-BW){rotated[BW-1]}},
					rotated[BW-1:0]};
			sat_pack_alu_pkg::OP_ZERO_WIDEN_BYTE_ADD:
				result_d = FIRST_OPERAND + {{(DATA_W-BW){1'b0}},
					rotated[BW-1:0]};
			sat_pack_alu_pkg::OP_SIGN_WIDEN_HALF_ADD:
				result_d = FIRST_OPERAND + {{(DATA_W-HW){rotated[HW-1]}},
					rotated[HW-1:0]};
			sat_pack_alu_pkg::OP_ZERO_WIDEN_HALF_ADD:
				result_d = FIRST_OPERAND + {{(DATA_W-HW){1'b0}},
					rotated[HW-1:0]};
			sat_pack_alu_pkg::OP_SIGN_WIDEN_DUAL_BYTE_ADD:
				result_d = add_halves(FIRST_OPERAND,
					widen_dual(rotated, 1'b1));
			sat_pack_alu_pkg::OP_ZERO_WIDEN_DUAL_BYTE_ADD:
				result_d = add_halves(FIRST_OPERAND,
					widen_dual(rotated, 1'b0));
			// Codes outside the set keep the old result and raise a flag.
			default:
				bad_d = 1'b1;
		endcase
	end

	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
			result_q <= `SPA_RESULT_RST;
		else if (START)
			result_q <= result_d;
	end

	// No operation of this unit alters flags, so they pass through as
	// given; the decoder may write them back without a special case.
	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
			flags_q <= `SPA_FLAGS_RST;
		else if (START)
			flags_q <= FLAGS_IN;
	end

	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			done_q <= 1'b0;
			bad_q <= 1'b0;
		end
		else
		begin
			done_q <= START;
			bad_q <= START & bad_d;
		end
	end

	assign RESULT = result_q;
	assign FLAGS_OUT = flags_q;
	assign DONE = done_q;
	assign BAD_OPCODE = bad_q;
endmodule : saturating_pack_extend_alu

// ==== test/regfile_model.sv ====
// Purpose: Destination register of the register file behind the unit.
// Assumes: Write-back happens on the cycle the unit reports done.
// Notes: Holds one register only; enough to watch write-back.
`timescale 1ns/1ps
module regfile_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic done,
	input wire logic bad,
	input wire logic [31:0] res,
	output logic [31:0] wb_q
);
	// A refused operation must not overwrite the destination register.
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			wb_q <= 32'h0;
		else if (done && !bad)
			wb_q <= res;
endmodule : regfile_model

// ==== test/sat_alu_props.sv ====
// Purpose: Port-level checker for the saturating pack and extend unit.
// Assumes: One clock domain, result one cycle after the taking edge.
// Notes: Only cases with a closed-form answer are asserted here.
`timescale 1ns/1ps
module sat_alu_props #(
	parameter int DATA_W = 32
) (
	input wire logic MCLK,
	input wire logic ARST_N,
	input wire logic START,
	input wire logic [4:0] OPCODE,
	input wire logic [DATA_W-1:0] FIRST_OPERAND,
	input wire logic [DATA_W-1:0] SECOND_OPERAND,
	input wire logic [4:0] SHIFT_AMOUNT,
	input wire logic [1:0] ROTATE_RIGHT_SELECT,
	input wire logic [3:0] FLAGS_IN,
	input wire logic [DATA_W-1:0] RESULT,
	input wire logic [3:0] FLAGS_OUT,
	input wire logic DONE,
	input wire logic BAD_OPCODE
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!ARST_N);
	sequence s_take;
		START ##1 DONE;
	endsequence
	chk_done_after: assert property (START |-> s_take)
		else $error("done missing after start");
	chk_no_spurious: assert property (!START |=> !DONE)
		else $error("done without start");
	chk_flags_kept:
	assert property (START |=> FLAGS_OUT == $past(FLAGS_IN))
		else $error("flags altered");
	chk_result_held: assert property (!START |=> $stable(RESULT))
		else $error("result moved while idle");
	chk_bad_keeps: assert property (START && OPCODE > 5'h11 |=>
		BAD_OPCODE && $stable(RESULT)) else $error("bad opcode handling");
	chk_pack_bt:
	assert property (START && OPCODE == 5'h04 && SHIFT_AMOUNT == 0 |=>
		RESULT == {$past(SECOND_OPERAND[31:16]), $past(FIRST_OPERAND[15:0])})
		else $error("pack bottom top wrong");
	chk_pack_tb_top:
	assert property (START && OPCODE == 5'h05 |=>
		RESULT[31:16] == $past(FIRST_OPERAND[31:16]))
		else $error("pack top bottom upper half wrong");
	chk_pack_tb_full:
	assert property (START && OPCODE == 5'h05 && SHIFT_AMOUNT == 0 |=>
		RESULT[15:0] == {16{$past(SECOND_OPERAND[31])}})
		else $error("full arithmetic shift wrong");
	chk_zero_byte:
	assert property (START && OPCODE == 5'h09 && ROTATE_RIGHT_SELECT == 0
		|=> RESULT == {24'h0, $past(SECOND_OPERAND[7:0])})
		else $error("zero widen byte wrong");
endmodule : sat_alu_props
bind saturating_pack_extend_alu sat_alu_props #(.DATA_W(DATA_W)) props (
	.MCLK(MCLK), .ARST_N(ARST_N), .START(START), .OPCODE(OPCODE),
	.FIRST_OPERAND(FIRST_OPERAND), .SECOND_OPERAND(SECOND_OPERAND),
	.SHIFT_AMOUNT(SHIFT_AMOUNT), .ROTATE_RIGHT_SELECT(ROTATE_RIGHT_SELECT),
	.FLAGS_IN(FLAGS_IN), .RESULT(RESULT), .FLAGS_OUT(FLAGS_OUT),
	.DONE(DONE), .BAD_OPCODE(BAD_OPCODE));

// ==== test/saturating_pack_extend_alu_tb.sv ====
// Purpose: Self-checking bench for the saturating pack and extend unit.
// Assumes: Inputs change on the falling edge of the clock.
// Notes: Expected values are worked out lane by lane by hand.
`timescale 1ns/1ps
module saturating_pack_extend_alu_tb;
	logic mclk = 0, arst_n = 0, start = 0, done, bad;
	logic [4:0] op = 5'h0, sh = 5'h0;
	logic [31:0] a = 32'h0, b = 32'h0, res, wb;
	logic [1:0] rot = 2'h0;
	logic [3:0] fl = 4'h0, fo;
	int errors = 0, checks_done = 0;
	always #12.5 mclk = ~mclk;
	saturating_pack_extend_alu DUT (.MCLK(mclk), .ARST_N(arst_n),
		.START(start), .OPCODE(op), .FIRST_OPERAND(a), .SECOND_OPERAND(b),
		.SHIFT_AMOUNT(sh), .ROTATE_RIGHT_SELECT(rot), .FLAGS_IN(fl),
		.RESULT(res), .FLAGS_OUT(fo), .DONE(done), .BAD_OPCODE(bad));
	regfile_model rf (.clk(mclk), .rst_n(arst_n), .done(done), .bad(bad),
		.res(res), .wb_q(wb));
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task run(input logic [4:0] o, input logic [31:0] x, y,
		input logic [4:0] s, input logic [1:0] r, input logic [31:0] e,
		input logic eb);
		@(negedge mclk);
		{start, op, a, b, sh, rot, fl} <= {1'b1, o, x, y, s, r, ~o[3:0]};
		@(negedge mclk);
		start <= 1'b0;
		chk("done", 32'h1, {31'h0, done});
		chk("bad", {31'h0, eb}, {31'h0, bad});
		chk("result", e, res);
		chk("flags", {28'h0, ~o[3:0]}, {28'h0, fo});
		@(negedge mclk);
		chk("writeback", e, wb);
	endtask : run
	task t_sat;
		run(5'h00, 32'hffff_0001, 32'h0002_0003, 0, 0, 32'hffff_0004, 0);
		run(5'h01, 32'hff10_0102, 32'h0220_ff03, 0, 0, 32'hff30_ff05, 0);
		run(5'h02, 32'h0005_8000, 32'h0006_0001, 0, 0, 32'h0000_7fff, 0);
		run(5'h03, 32'h1080_0002, 32'h2001_0001, 0, 0, 32'h007f_0001, 0);
	endtask : t_sat
	task t_pack;
		run(5'h04, 32'h1234_5678, 32'habcd_ef01, 0, 0, 32'habcd_5678, 0);
		run(5'h04, 32'h1234_5678, 32'habcd_ef01, 4, 0, 32'hbcde_5678, 0);
		run(5'h05, 32'h1234_5678, 32'h8000_0000, 0, 0, 32'h1234_ffff, 0);
		run(5'h05, 32'h1234_5678, 32'h0002_4680, 1, 0, 32'h1234_2340, 0);
	endtask : t_pack
	task t_widen;
		logic [31:0] sb [4];
		sb = '{32'h0000_0001, 32'hffff_ffff, 32'h0000_0070, 32'hffff_ff80};
		for (int i = 0; i < 4; i++)
			run(5'h06, 0, 32'h8070_ff01, 0, i[1:0], sb[i], 0);
		run(5'h07, 0, 32'h8070_ff01, 0, 0, 32'hffff_ff01, 0);
		run(5'h08, 0, 32'h8070_ff01, 0, 1, 32'hff80_ffff, 0);
		run(5'h09, 0, 32'h8070_ff01, 0, 0, 32'h0000_0001, 0);
		run(5'h0a, 0, 32'h8070_ff01, 0, 2, 32'h0000_8070, 0);
		run(5'h0b, 0, 32'h8070_ff01, 0, 1, 32'h0080_00ff, 0);
	endtask : t_widen
	task t_widen_add;
		logic [31:0] f;
		f = 32'h0001_fff0;
		run(5'h0c, f, 32'h8070_ff01, 0, 1, 32'h0001_ffef, 0);
		run(5'h0d, f, 32'h8070_ff01, 0, 0, 32'h0001_fef1, 0);
		run(5'h0e, f, 32'h8070_ff01, 0, 1, 32'hff81_ffef, 0);
		run(5'h0f, f, 32'h8070_ff01, 0, 3, 32'h0002_0070, 0);
		run(5'h10, f, 32'h8070_ff01, 0, 0, 32'h0002_fef1, 0);
		run(5'h11, f, 32'h8070_ff01, 0, 0, 32'h0071_fff1, 0);
	endtask : t_widen_add
	task t_bad;
		run(5'h12, 32'h1, 32'h2, 0, 0, 32'h0071_fff1, 1);
		run(5'h1f, 32'h1, 32'h2, 0, 0, 32'h0071_fff1, 1);
	endtask : t_bad
	task print_verdict;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	initial
	begin
		repeat (16) @(negedge mclk);
		chk("reset result", 32'h0, res);
		chk("reset done", 32'h0, {31'h0, done});
		arst_n <= 1'b1;
		t_sat();
		t_pack();
		t_widen();
		t_widen_add();
		t_bad();
		print_verdict();
	end
endmodule : saturating_pack_extend_alu_tb
